// >>> include/its_link_if.sv
// link-domain signals between the controller top and its slave responder
// assumes both ends run on the link clock
`timescale 1ns/1ps
interface its_link_if;
	logic        scl_f;
	logic        sda_f;
	logic [6:0]  own_lo;
	logic [2:0]  own_hi;
	logic        ten;
	logic        en;
	logic [15:0] slave_setup_cycles;
	logic        m_busy;
	logic        s_scl_low;
	logic        s_sda_low;
	logic        s_hit;
	modport ctl (output scl_f, sda_f, own_lo, own_hi, ten, en, slave_setup_cycles, m_busy,
		input s_scl_low, s_sda_low, s_hit);
	modport slv (input scl_f, sda_f, own_lo, own_hi, ten, en, slave_setup_cycles, m_busy,
		output s_scl_low, s_sda_low, s_hit);
endinterface

// >>> include/its_pkg.sv
// constants shared by the two-wire transaction setup block
// assumes a 32-bit apb slave port and a separate link clock
package its_pkg;
	// register byte offsets
	localparam logic [11:0] CTRL_OFS  = 12'h000;
	localparam logic [11:0] SETUP_OFS = 12'h004;
	localparam logic [11:0] CMD_OFS   = 12'h00c;
	// controller_control fields
	localparam int CTRL_EN_BIT  = 0;
	localparam int CTRL_TEN_BIT = 1;
	localparam int FILT_LSB     = 13;
	localparam int FSTOP_BIT    = 15;
	localparam int BUSY_BIT     = 16;
	localparam int HIT_BIT      = 17;
	localparam int HOLD_BIT     = 18;
	localparam int NACK_BIT     = 19;
	// slave_own_address_setup fields
	localparam int OWN_LO_LSB = 0;
	localparam int OWN_HI_LSB = 7;
	localparam int SLAVE_SETUP_CYCLES_LSB   = 16;
	localparam logic [6:0]  OWN_LO_RST = 7'h55;
	localparam logic [15:0] SLAVE_SETUP_CYCLES_RST   = 16'h000f;
	// master_command fields
	localparam int RNW_BIT  = 0;
	localparam int TLO_LSB  = 1;
	localparam int THI_LSB  = 8;
	localparam int SB_BIT   = 11;
	localparam int AK_LSB   = 12;
	localparam int STOP_BIT = 14;
	localparam int CMD_W    = 15;
	localparam logic [1:0] AK_GC  = 2'h0;
	localparam logic [1:0] AK_7B  = 2'h1;
	localparam logic [1:0] AK_10B = 2'h2;
	// item kinds of the master sequence
	localparam logic [1:0] IT_BYTE = 2'h0;
	localparam logic [1:0] IT_RS   = 2'h1;
	localparam logic [1:0] IT_END  = 2'h2;
	// serial clock timing on the link clock
	localparam int unsigned LINK_CLK_NS = 125;
	localparam int unsigned SCL_QTR_NS  = 2500;
	localparam int unsigned QTR_CYC     = (SCL_QTR_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
	localparam logic [4:0]  QTR_LAST    = 5'(QTR_CYC - 1);
endpackage

// >>> rtl/its_glitch_filter.sv
// spike filter for one serial line: three-flop sync then width filter
// assumes clk is the link clock and sel is stable in that domain
`timescale 1ns/1ps
module its_glitch_filter (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       d_async,
	input  wire logic [1:0] sel,
	output logic            q
);
	logic       s1_r, s2_r, s3_r, clean_r;
	logic [2:0] cnt_r;
	logic [2:0] lim;

	// widest spike to drop for each select
	assign lim = (sel == 2'h3) ? 3'h4 : {1'b0, sel};

	// synchroniser, a change counts once stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r    <= 1'b1;
			s2_r    <= 1'b1;
			s3_r    <= 1'b1;
			clean_r <= 1'b1;
		end else begin
			s1_r <= d_async;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				clean_r <= s3_r;
		end
	end

	// output follows only after lim+1 differing samples
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q     <= 1'b1;
			cnt_r <= 3'h0;
		end else if (sel == 2'h0) begin
			q     <= clean_r;
			cnt_r <= 3'h0;
		end else if (clean_r == q) begin
			cnt_r <= 3'h0;
		end else if (cnt_r == lim) begin
			q     <= clean_r;
			cnt_r <= 3'h0;
		end else begin
			cnt_r <= cnt_r + 3'h1;
		end
	end
endmodule // its_glitch_filter

// >>> rtl/its_slave.sv
// own-address responder: acks a matching 7- or 10-bit address
// assumes filtered lines and stable config on the link clock
`timescale 1ns/1ps
module its_slave (
	input  wire logic clk,
	input  wire logic rst_n,
	its_link_if.slv   lk
);
	logic        scl_d_r, sda_d_r, act_r, ack_r, stretch_r, first_ok_r;
	logic [3:0]  bitc_r;
	logic [7:0]  sh_r;
	logic        byte_no_r;
	logic [15:0] su_r;
	logic        match, final_b;

	// address compare for the byte just shifted in
	always_comb begin
		match   = 1'b0;
		final_b = 1'b0;
		if (!lk.ten) begin
			match   = (sh_r[7:1] == lk.own_lo);
			final_b = 1'b1;
		end else if (!byte_no_r) begin
			match = (sh_r[7:1] == {5'h1e, lk.own_hi[2:1]}) && !sh_r[0];
		end else begin
			match   = first_ok_r && (sh_r == {lk.own_hi[0], lk.own_lo});
			final_b = 1'b1;
		end
	end

	// edge history of the filtered lines
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= lk.scl_f;
			sda_d_r <= lk.sda_f;
		end
	end

	// byte framing, ack and clock stretch with data setup
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			act_r <= 1'b0; ack_r <= 1'b0; stretch_r <= 1'b0;
			first_ok_r <= 1'b0; bitc_r <= 4'h0; sh_r <= 8'h00;
			byte_no_r <= 1'b0; su_r <= 16'h0000; lk.s_hit <= 1'b0;
		end else if (lk.scl_f && scl_d_r && sda_d_r && !lk.sda_f) begin
			act_r <= lk.en && !lk.m_busy; // start seen
			bitc_r <= 4'h0; byte_no_r <= 1'b0; first_ok_r <= 1'b0;
			lk.s_hit <= 1'b0;
		end else if (lk.scl_f && scl_d_r && !sda_d_r && lk.sda_f) begin
			act_r <= 1'b0; ack_r <= 1'b0; stretch_r <= 1'b0; // stop seen
		end else if (stretch_r) begin
			if (su_r <= 16'h0001)
				stretch_r <= 1'b0;
			else
				su_r <= su_r - 16'h0001;
		end else if (act_r && lk.scl_f && !scl_d_r) begin
			sh_r   <= {sh_r[6:0], lk.sda_f};
			bitc_r <= bitc_r + 4'h1;
		end else if (act_r && !lk.scl_f && scl_d_r) begin
			if (bitc_r == 4'h8) begin
				if (match) begin
					ack_r     <= 1'b1;
					stretch_r <= (lk.slave_setup_cycles > 16'h0001);
					su_r      <= lk.slave_setup_cycles - 16'h0001;
				end else begin
					act_r <= 1'b0;
				end
			end else if (bitc_r == 4'h9) begin
				ack_r      <= 1'b0;
				bitc_r     <= 4'h0;
				byte_no_r  <= 1'b1;
				first_ok_r <= 1'b1;
				if (final_b) begin
					lk.s_hit <= 1'b1;
					act_r    <= 1'b0;
				end
			end
		end
	end

	assign lk.s_scl_low = stretch_r;
	assign lk.s_sda_low = ack_r;
endmodule // its_slave

// >>> rtl/its_top.sv
// apb register file and link-side master sequencer of the serial controller
// assumes pclk for apb and an unrelated link_clk for the serial engine
// Overview of operation
// - the filter select puts no filter at zero and drops spikes of 1, 2 or 4 link cycles at one, two, three.
// - writing one to the forced-halt bit makes the controller put a STOP on the bus.
// - the own slave address sits in bits 6:0 and resets to 0x55.
// - in 10-bit slave mode bits 9:7 give the three upper own-address bits.
// - after a stretched clock the slave waits the setup value minus one link cycles, reset value 0xF.
// - command bit 0 chooses write at zero and read at one.
// - command bits 7:1 hold the target address and bits 10:8 its upper three bits.
// - command bit 11 prefixes the start byte procedure when set.
// - the address kind field picks general call, 7-bit or 10-bit addressing.
// - command bit 14 ends with STOP when set, otherwise the next operation opens with a repeated START.
`timescale 1ns/1ps
module its_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        link_clk,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe
);
	typedef enum {M_IDLE, M_START, M_ITEM, M_BITS, M_RS, M_STOP, M_HOLD} its_mst_e;

	its_link_if lk ();

	// pclk domain registers
	logic        en_r, ten_r, fstop_r;
	logic [1:0]  filt_r;
	logic [6:0]  own_lo_r;
	logic [2:0]  own_hi_r;
	logic [15:0] slave_setup_cycles_r;
	logic [14:0] cmd_r;
	logic        cfg_tg_r, cmd_tg_r, stop_tg_r;
	logic [3:0]  st_s1_r, st_s2_r, st_s3_r, stat_r;
	logic [3:0]  stat_lk;

	// link domain registers
	logic        lrst1_r, lrst_n;
	logic [2:0]  tg_s1_r, tg_s2_r, tg_s3_r;
	logic [2:0]  tg_ev;
	logic [1:0]  l_filt_r;
	logic [14:0] l_cmd_r;
	logic        l_stop_flag;
	its_mst_e    st_r;
	logic [1:0]  q_r;
	logic [3:0]  bitn_r;
	logic [2:0]  step_r;
	logic [7:0]  sh_r;
	logic        noack_r, nack_r, m_scl_r, m_sda_r, pin_lo_r;
	logic [4:0]  div_r;
	logic        tick, adv;
	logic [10:0] item;
	logic [1:0]  scl_sda_f;

	// register select, also used to flag unmapped addresses
	function automatic logic [2:0] reg_sel(input logic [11:0] a);
		reg_sel = {a == its_pkg::CMD_OFS, a == its_pkg::SETUP_OFS, a == its_pkg::CTRL_OFS};
	endfunction

	// next item of the master sequence: {kind, byte, low bit always cleared}
	function automatic logic [10:0] step_item(input logic [2:0] st, input logic [14:0] c);
		logic [2:0] s;
		logic [7:0] hb;
		s  = c[its_pkg::SB_BIT] ? st - 3'h2 : st;
		hb = 8'hf0 | {5'h00, c[its_pkg::THI_LSB+2], c[its_pkg::THI_LSB+1], 1'b0};
		step_item = {its_pkg::IT_END, 8'h00, 1'b0};
		if (c[its_pkg::SB_BIT] && st == 3'h0)
			step_item = {its_pkg::IT_BYTE, 8'h01, 1'b1};
		else if (c[its_pkg::SB_BIT] && st == 3'h1)
			step_item = {its_pkg::IT_RS, 8'h00, 1'b0};
		else begin
			case (c[its_pkg::AK_LSB +: 2])
				its_pkg::AK_GC: begin
					if (s == 3'h0)
						step_item = {its_pkg::IT_BYTE, 8'h00, 1'b0};
				end
				its_pkg::AK_7B: begin
					if (s == 3'h0)
						step_item = {its_pkg::IT_BYTE, c[7:1], c[its_pkg::RNW_BIT], 1'b0};
				end
				its_pkg::AK_10B: begin
					if (s == 3'h0)
						step_item = {its_pkg::IT_BYTE, hb, 1'b0};
					else if (s == 3'h1)
						step_item = {its_pkg::IT_BYTE, c[its_pkg::THI_LSB], c[7:1], 1'b0};
					else if (s == 3'h2 && c[its_pkg::RNW_BIT])
						step_item = {its_pkg::IT_RS, 8'h00, 1'b0};
					else if (s == 3'h3 && c[its_pkg::RNW_BIT])
						step_item = {its_pkg::IT_BYTE, hb | 8'h01, 1'b0};
				end
				default: step_item = {its_pkg::IT_END, 8'h00, 1'b0};
			endcase
		end
		step_item[0] = 1'b0;
	endfunction

	// apb answer: always ready, data and error captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (psel && !penable) begin
				pslverr <= (reg_sel(paddr) == 3'h0);
				prdata  <= 32'h0000_0000;
				case (reg_sel(paddr))
					3'h1: prdata <= {12'h000, stat_r, fstop_r, filt_r, 11'h000, ten_r, en_r};
					3'h2: prdata <= {slave_setup_cycles_r, 6'h00, own_hi_r, own_lo_r};
					3'h4: prdata <= {17'h0_0000, cmd_r};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// register writes, one-shot events as toggles toward the link
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_r <= 1'b0; ten_r <= 1'b0; fstop_r <= 1'b0; filt_r <= 2'h0;
			own_lo_r <= its_pkg::OWN_LO_RST; own_hi_r <= 3'h0;
			slave_setup_cycles_r <= its_pkg::SLAVE_SETUP_CYCLES_RST; cmd_r <= 15'h0000;
			cfg_tg_r <= 1'b0; cmd_tg_r <= 1'b0; stop_tg_r <= 1'b0;
		end else if (psel && penable && pready && pwrite) begin
			case (reg_sel(paddr))
				3'h1: begin
					en_r     <= pwdata[its_pkg::CTRL_EN_BIT];
					ten_r    <= pwdata[its_pkg::CTRL_TEN_BIT];
					filt_r   <= pwdata[its_pkg::FILT_LSB +: 2];
					fstop_r  <= pwdata[its_pkg::FSTOP_BIT];
					cfg_tg_r <= ~cfg_tg_r;
					if (pwdata[its_pkg::FSTOP_BIT])
						stop_tg_r <= ~stop_tg_r;
				end
				3'h2: begin
					own_lo_r <= pwdata[its_pkg::OWN_LO_LSB +: 7];
					own_hi_r <= pwdata[its_pkg::OWN_HI_LSB +: 3];
					slave_setup_cycles_r   <= pwdata[its_pkg::SLAVE_SETUP_CYCLES_LSB +: 16];
					cfg_tg_r <= ~cfg_tg_r;
				end
				3'h4: begin
					cmd_r    <= pwdata[its_pkg::CMD_W-1:0];
					cmd_tg_r <= ~cmd_tg_r;
				end
				default: cmd_tg_r <= cmd_tg_r;
			endcase
		end
	end

	// link status into pclk through three flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_s1_r <= 4'h0;
			st_s2_r <= 4'h0;
			st_s3_r <= 4'h0;
			stat_r  <= 4'h0;
		end else begin
			st_s1_r <= stat_lk;
			st_s2_r <= st_s1_r;
			st_s3_r <= st_s2_r;
			if (st_s2_r == st_s3_r)
				stat_r <= st_s3_r;
		end
	end

	// link reset release synchronised to link_clk
	always_ff @(posedge link_clk or negedge presetn) begin
		if (!presetn) begin
			lrst1_r <= 1'b0;
			lrst_n  <= 1'b0;
		end else begin
			lrst1_r <= 1'b1;
			lrst_n  <= lrst1_r;
		end
	end

	// event toggles into the link domain
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			tg_s1_r <= 3'h0;
			tg_s2_r <= 3'h0;
			tg_s3_r <= 3'h0;
		end else begin
			tg_s1_r <= {stop_tg_r, cmd_tg_r, cfg_tg_r};
			tg_s2_r <= tg_s1_r;
			tg_s3_r <= tg_s2_r;
		end
	end
	assign tg_ev = tg_s2_r ^ tg_s3_r;

	// config copies taken on the config event; source is stable by then
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			l_filt_r <= 2'h0; lk.en <= 1'b0; lk.ten <= 1'b0;
			lk.own_lo <= its_pkg::OWN_LO_RST; lk.own_hi <= 3'h0;
			lk.slave_setup_cycles <= its_pkg::SLAVE_SETUP_CYCLES_RST;
		end else if (tg_ev[0]) begin
			l_filt_r <= filt_r;
			lk.en <= en_r; lk.ten <= ten_r;
			lk.own_lo <= own_lo_r;
			lk.own_hi <= own_hi_r;
			lk.slave_setup_cycles <= slave_setup_cycles_r;
		end
	end

	// one filter per serial line
	generate
		for (genvar g = 0; g < 2; g++) begin : g_filt
			its_glitch_filter u_filt (
				.clk     (link_clk),
				.rst_n   (lrst_n),
				.d_async (g == 0 ? scl_i : sda_i),
				.sel     (l_filt_r),
				.q       (scl_sda_f[g])
			);
		end
	endgenerate
	assign lk.scl_f = scl_sda_f[0];
	assign lk.sda_f = scl_sda_f[1];

	its_slave u_slave (
		.clk   (link_clk),
		.rst_n (lrst_n),
		.lk    (lk)
	);

	// quarter-period divider; stall while another party stretches scl
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n)
			div_r <= its_pkg::QTR_LAST;
		else if (tick)
			div_r <= its_pkg::QTR_LAST;
		else
			div_r <= div_r - 5'h01;
	end
	assign tick = (div_r == 5'h00);
	assign adv  = tick && !(!m_scl_r && !lk.scl_f);
	assign item = step_item(step_r, l_cmd_r);
	assign l_stop_flag = l_cmd_r[its_pkg::STOP_BIT];

	// master sequencer
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			st_r <= M_IDLE; q_r <= 2'h0; bitn_r <= 4'h0; step_r <= 3'h0;
			sh_r <= 8'h00; noack_r <= 1'b0; nack_r <= 1'b0;
			m_scl_r <= 1'b0; m_sda_r <= 1'b0; l_cmd_r <= 15'h0000;
		end else if (tg_ev[2] && st_r != M_STOP) begin
			st_r <= M_STOP;
			q_r  <= 2'h0;
		end else begin
			case (st_r)
				M_IDLE: begin
					if (tg_ev[1] && lk.en) begin
						l_cmd_r <= cmd_r;
						st_r <= M_START; q_r <= 2'h0; step_r <= 3'h0; nack_r <= 1'b0;
					end
				end
				M_START: begin
					if (adv) begin
						q_r <= q_r + 2'h1;
						if (q_r == 2'h0)
							m_sda_r <= 1'b1;
						else begin
							m_scl_r <= 1'b1;
							st_r <= M_ITEM;
						end
					end
				end
				M_ITEM: begin
					step_r <= step_r + 3'h1;
					q_r <= 2'h0;
					bitn_r <= 4'h0;
					sh_r <= item[8:1];
					noack_r <= (item[8:1] == 8'h01) && l_cmd_r[its_pkg::SB_BIT] && step_r == 3'h0;
					if (item[10:9] == its_pkg::IT_BYTE)
						st_r <= M_BITS;
					else if (item[10:9] == its_pkg::IT_RS)
						st_r <= M_RS;
					else
						st_r <= l_stop_flag ? M_STOP : M_HOLD;
				end
				M_BITS: begin
					if (adv) begin
						q_r <= q_r + 2'h1;
						case (q_r)
							2'h0: m_sda_r <= (bitn_r == 4'h8) ? 1'b0 : ~sh_r[7];
							2'h1: m_scl_r <= 1'b0;
							2'h2: if (bitn_r == 4'h8 && !noack_r) nack_r <= lk.sda_f;
							default: begin
								m_scl_r <= 1'b1;
								bitn_r <= bitn_r + 4'h1;
								sh_r <= {sh_r[6:0], 1'b0};
								if (bitn_r == 4'h8)
									st_r <= M_ITEM;
							end
						endcase
					end
				end
				M_RS: begin
					if (adv) begin
						q_r <= q_r + 2'h1;
						case (q_r)
							2'h0: m_sda_r <= 1'b0;
							2'h1: m_scl_r <= 1'b0;
							2'h2: m_sda_r <= 1'b1;
							default: begin
								m_scl_r <= 1'b1;
								st_r <= M_ITEM;
							end
						endcase
					end
				end
				M_STOP: begin
					if (adv) begin
						q_r <= q_r + 2'h1;
						case (q_r)
							2'h0: m_sda_r <= 1'b1;
							2'h1: m_scl_r <= 1'b0;
							2'h2: m_sda_r <= 1'b0;
							default: st_r <= M_IDLE;
						endcase
					end
				end
				M_HOLD: begin
					// scl held low until the follow-up operation arrives
					if (tg_ev[1] && lk.en) begin
						l_cmd_r <= cmd_r;
						st_r <= M_RS; q_r <= 2'h0; step_r <= 3'h0; nack_r <= 1'b0;
					end
				end
				default: st_r <= M_IDLE;
			endcase
		end
	end

	assign lk.m_busy = (st_r != M_IDLE);
	assign stat_lk = {nack_r, st_r == M_HOLD, lk.s_hit, st_r != M_IDLE};

	// open-drain pins: drive low only, enables merge master and slave
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			pin_lo_r <= 1'b0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			pin_lo_r <= 1'b0;
			scl_oe <= m_scl_r | lk.s_scl_low;
			sda_oe <= m_sda_r | lk.s_sda_low;
		end
	end
	assign scl_o = pin_lo_r;
	assign sda_o = pin_lo_r;
endmodule // its_top

// >>> tb/its_bus_dev.sv
// bus-side device model: byte monitor, acker, small master
// assumes the bench resolves both lines with pull-ups
`timescale 1ns/1ps
module its_bus_dev (
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_low,
	output logic      sda_low
);
	logic [7:0] sh;
	logic [7:0] got[$];
	int         nb;
	int         starts;
	int         stops;
	bit         mon;
	initial begin
		scl_low = 0;
		sda_low = 0;
		nb = 0;
		mon = 0;
	end
	// start and stop conditions seen on the wire
	always @(negedge sda) if (scl) begin
		starts++;
		nb = 0;
	end
	always @(posedge sda) if (scl)
		stops++;
	// shift on scl rise, one byte per eight bits
	always @(posedge scl) begin
		if (nb < 8)
			sh = {sh[6:0], sda};
		nb++;
		if (nb == 8)
			got.push_back(sh);
		if (nb == 9)
			nb = 0;
	end
	// ack each byte the controller sends
	always @(negedge scl) if (!mon)
		sda_low <= (nb == 8);
	task automatic m_start();
		mon = 1;
		sda_low = 1;
		#2500 scl_low = 1;
		#2500;
	endtask
	// one byte msb first; returns ack and the stretch seen after bit eight
	task automatic m_byte(input logic [7:0] b, input bit spk, output logic ack, output int st);
		time t;
		for (int i = 7; i >= 0; i--) begin
			sda_low = !b[i];
			#2500 scl_low = 0;
			wait (scl);
			if (spk && b[i]) begin
				#1000 sda_low = 1;
				#450 sda_low = 0;
				#1050;
			end else
				#2500;
			scl_low = 1;
			t = $time;
			#1000;
		end
		sda_low = 0;
		// leave room for the slave's filtered view before releasing scl
		#1500 scl_low = 0;
		wait (scl);
		st = int'($time - t);
		ack = !sda;
		#2500 scl_low = 1;
		#2500;
	endtask
	task automatic m_stop();
		sda_low = 1;
		#1250 scl_low = 0;
		wait (scl);
		#2500 sda_low = 0;
		#2500 mon = 0;
	endtask
endmodule // its_bus_dev

// >>> tb/its_top_chk.sv
// port assertions for the serial controller top
// assumes it is bound onto its_top
`timescale 1ns/1ps
module its_top_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        link_clk,
	input wire logic        scl_i,
	input wire logic        scl_o,
	input wire logic        scl_oe,
	input wire logic        sda_o,
	input wire logic        sda_oe
);
	logic ok_a;
	logic rd;
	// decode of the three mapped words
	assign ok_a = paddr == its_pkg::CTRL_OFS || paddr == its_pkg::SETUP_OFS || paddr == its_pkg::CMD_OFS;
	assign rd = psel && penable && !pwrite;
	chk_ready_rst: assert property (@(posedge pclk) disable iff (!presetn) $past(presetn) |-> pready)
		else $error("pready low after reset");
	chk_zero_wait: assert property (@(posedge pclk) disable iff (!presetn) psel && !penable |=> pready)
		else $error("access phase not ready");
	chk_bad_addr: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !ok_a |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped not refused");
	chk_good_addr: assert property (@(posedge pclk) disable iff (!presetn) psel && penable && ok_a |-> !pslverr)
		else $error("mapped access refused");
	chk_rdata_hold: assert property (@(posedge pclk) disable iff (!presetn) psel && penable |=> $stable(prdata))
		else $error("read data not held");
	chk_setup_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
		rd && paddr == its_pkg::SETUP_OFS |-> prdata[15:10] == 6'h00) else $error("setup gap bits set");
	chk_cmd_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
		rd && paddr == its_pkg::CMD_OFS |-> prdata[31:15] == 17'h0_0000) else $error("command upper bits set");
	chk_open_drain: assert property (@(posedge link_clk) disable iff (!presetn) !scl_o && !sda_o)
		else $error("line driven high");
	chk_stop_quiet: assert property (@(posedge link_clk) disable iff (!presetn)
		$fell(sda_oe) && scl_i |-> (!sda_oe && !scl_oe) [*8]) else $error("bus busy right after stop");
	chk_start_len: assert property (@(posedge link_clk) disable iff (!presetn)
		$rose(sda_oe) && !scl_oe |=> sda_oe [*8]) else $error("start low too short");
endmodule // its_top_chk
bind its_top its_top_chk u_its_top_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
	.pslverr, .link_clk, .scl_i, .scl_o, .scl_oe, .sda_o, .sda_oe);

// >>> tb/its_top_tb.sv
// self-checking bench for the serial controller top
// assumes its_bus_dev on the pulled-up lines and apb at 20 MHz
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module its_top_tb;
	localparam logic [11:0] CT = its_pkg::CTRL_OFS;
	localparam logic [11:0] SU = its_pkg::SETUP_OFS;
	localparam logic [11:0] CM = its_pkg::CMD_OFS;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, link_clk = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic        pready, pslverr, sl, ack, scl_o, scl_oe, sda_o, sda_oe, scl_pl, sda_pl, scl, sda;
	int          fails = 0, compares = 0, cyc = 0, st;
	logic [15:0] cmd_t[5] = '{16'h5075, 16'h40ff, 16'h6556, 16'h5822, 16'h6203};
	logic [23:0] byt_t[5] = '{24'h75_0000, 24'h00_0000, 24'hf4_ab00, 24'h01_2200, 24'hf2_01f3};
	int          n_t[5] = '{1, 1, 2, 2, 3};
	int          s_t[5] = '{1, 1, 1, 2, 2};
	// clocks, link clock unrelated in phase to pclk
	always #25 pclk = ~pclk;
	always #62.5 link_clk = ~link_clk;
	// wired-and lines with pull-ups
	assign scl = !(scl_oe || scl_pl);
	assign sda = !(sda_oe || sda_pl);
	its_top u_its_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .link_clk, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o, .sda_oe);
	its_bus_dev u_its_bus_dev (.scl, .sda, .scl_low(scl_pl), .sda_low(sda_pl));
	task automatic wrap_up();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// one apb transfer; result in q and sl
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel   <= 1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		sl = pslverr;
		psel    <= 0;
		penable <= 0;
		if (n == 20)
			fails++;
		if (w)
			repeat (12) @(posedge pclk);
	endtask
	// issue a command and wait until idle or holding
	task automatic run_cmd(input logic [31:0] c);
		int n;
		n = 0;
		u_its_bus_dev.got.delete();
		u_its_bus_dev.starts = 0;
		u_its_bus_dev.stops = 0;
		apb(1, CM, c);
		repeat (60) @(posedge pclk);
		do begin
			apb(0, CT, 0);
			n++;
		end while (q[16] && !q[18] && n < 5000);
		if (n == 5000)
			fails++;
		repeat (40) @(posedge pclk);
	endtask
	// ceiling on run length
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fails++;
			wrap_up();
		end
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		repeat (20) @(posedge pclk);
		apb(0, CT, 0);
		`CHK("ctrl rst", 32'h0000_0000, q)
		apb(0, SU, 0);
		`CHK("setup rst", 32'h000f_0055, q)
		apb(0, CM, 0);
		`CHK("cmd rst", 32'h0000_0000, q)
		apb(1, SU, 32'hffff_ffff);
		apb(0, SU, 0);
		`CHK("setup rw", 32'hffff_03ff, q)
		apb(1, CM, 32'hffff_ffff);
		apb(0, CM, 0);
		`CHK("cmd rw", 32'h0000_7fff, q)
		apb(0, 12'h008, 0);
		`CHK("bad rd err", 1'b1, sl)
		`CHK("bad rd data", 32'h0000_0000, q)
		apb(1, 12'h010, 32'h1234_5678);
		`CHK("bad wr err", 1'b1, sl)
		$display("test registers done");
		apb(1, CT, 32'h0000_0001);
		foreach (cmd_t[i]) begin
			run_cmd({16'h0000, cmd_t[i]});
			`CHK("nbytes", n_t[i], u_its_bus_dev.got.size())
			for (int k = 0; k < n_t[i]; k++)
				`CHK("addr byte", byt_t[i][23 - 8 * k -: 8], u_its_bus_dev.got[k])
			`CHK("starts", s_t[i], u_its_bus_dev.starts)
			`CHK("stops", 1, u_its_bus_dev.stops)
		end
		$display("test master done");
		run_cmd(32'h0000_1075);
		`CHK("no stop", 0, u_its_bus_dev.stops)
		`CHK("holding", 1'b1, q[18])
		run_cmd(32'h0000_5075);
		`CHK("rs start", 1, u_its_bus_dev.starts)
		`CHK("rs stop", 1, u_its_bus_dev.stops)
		run_cmd(32'h0000_1075);
		u_its_bus_dev.stops = 0;
		apb(1, CT, 32'h0000_8001);
		repeat (400) @(posedge pclk);
		`CHK("forced stop", 1, u_its_bus_dev.stops)
		apb(0, CT, 0);
		`CHK("halt bit", 16'h8001, q[15:0])
		$display("test hold done");
		apb(1, CT, 32'h0000_6001);
		apb(1, SU, 32'h0028_0055);
		apb(0, CT, 0);
		`CHK("filter sel", 16'h6001, q[15:0])
		u_its_bus_dev.m_start();
		u_its_bus_dev.m_byte(8'haa, 1, ack, st);
		u_its_bus_dev.m_stop();
		`CHK("own ack", 1'b1, ack)
		`CHK("stretch", 1'b1, st >= 4875 && st <= 6500)
		repeat (40) @(posedge pclk);
		apb(0, CT, 0);
		`CHK("own hit", 1'b1, q[17])
		u_its_bus_dev.m_start();
		u_its_bus_dev.m_byte(8'hac, 0, ack, st);
		u_its_bus_dev.m_stop();
		`CHK("other nack", 1'b0, ack)
		apb(1, SU, 32'h0005_0313);
		apb(1, CT, 32'h0000_0003);
		u_its_bus_dev.m_start();
		u_its_bus_dev.m_byte(8'hf6, 0, ack, st);
		u_its_bus_dev.m_byte(8'h13, 0, ack, st);
		u_its_bus_dev.m_stop();
		`CHK("ten ack", 1'b1, ack)
		repeat (40) @(posedge pclk);
		apb(0, CT, 0);
		`CHK("ten hit", 1'b1, q[17])
		$display("test slave done");
		wrap_up();
	end
endmodule // its_top_tb
